// ===== hk_regs_pkg.sv
// package for the housekeeping result and power toggle register slice
// assumes a plain address/strobe register port with 10-bit data
package hk_regs_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_POWER_TOGGLE_PULSES    = 5'h04;
	localparam logic [4:0] ADDR_BACKUP_BATTERY_RESULT  = 5'h12;
	localparam logic [4:0] ADDR_AUX_INPUT_ONE_RESULT   = 5'h13;
	localparam logic [4:0] ADDR_AUX_INPUT_TWO_RESULT   = 5'h14;
	localparam logic [4:0] ADDR_AUX_INPUT_THREE_RESULT = 5'h15;
	localparam logic [4:0] ADDR_AUX_INPUT_FOUR_RESULT  = 5'h16;
	localparam logic [4:0] ADDR_CONV_STATUS            = 5'h18;
	localparam logic [4:0] ADDR_POWER_LATCHES          = 5'h1A;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int         DATA_W            = 10;
	localparam int         LATCH_W           = 5;
	localparam int         CHAN_W            = 3;
	localparam int         NUM_CHANNELS      = 5;
	localparam int         BIT_HK_CONV_LATCH = 4;
	localparam int         BIT_VOICE_DOWN    = 1;
	localparam int         BIT_VOICE_UP      = 0;
	localparam int         BIT_BUSY          = 0;
	localparam logic [9:0] RESULT_RESET      = 10'h000;
	localparam logic [4:0] LATCH_RESET       = 5'h00;
	localparam logic [9:0] READ_ZERO         = 10'h000;

	// conversion result delivered by the converter front end
	typedef struct packed {
		logic [2:0] channel;
		logic [9:0] value;
	} conv_result_t;

	// register port request
	typedef struct packed {
		logic [4:0] addr;
		logic [9:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage

// ===== hk_regs.sv
// housekeeping converter result registers and power toggle latches
// assumes converter busy and result come from logic on i_clock
//
// Function
// - backup battery result at 18, read-only, zero reset
// - aux input one result at 19
// - aux input two result at 20
// - aux input three result at 21
// - aux input four result at 22
// - toggle register at 4 stores nothing
// - zero toggle bit leaves latch unchanged
// - set and clear together clears latch
// - bits 9/8 set/clear converter latch bit 4
// - bits 7/6 set/clear correction DAC latch bit 3
// - bits 5/4 set/clear aux DAC latch bit 2
// - bits 3/2 set/clear downlink latch bit 1
// - bits 1/0 set/clear uplink latch bit 0
// - status bit 0 high while converting
// - cleared latch holds unit powered down
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module hk_regs
(
	input  wire logic                       i_clock,
	input  wire logic                       i_rst_n,
	input  wire logic                       i_enable,
	input  wire hk_regs_pkg::reg_req_t      i_req,
	input  wire logic                       i_conv_busy,
	input  wire hk_regs_pkg::conv_result_t  i_conv_result,
	output logic [9:0]                      o_rdata,
	output logic                            o_conversion_in_progress,
	output logic [4:0]                      o_power_enables
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0][9:0] result;
		logic [4:0]      latch;
		logic            busy_seen;
		logic [9:0]      rdata;
	} state_t;

	state_t state;
	state_t next_state;

	// apply a write of the toggle register to the latches; clear wins
	function automatic logic [4:0] apply_toggles(input logic [4:0] cur, input logic [9:0] wd);
		logic [4:0] res;
		res = cur;
		for (int i = 0; i < hk_regs_pkg::LATCH_W; i++)
		begin
			if (wd[2*i+1])
				res[i] = 1'b1;
			if (wd[2*i])
				res[i] = 1'b0;
		end
		return res;
	endfunction

	// true for a write strobe aimed at the toggle register
	function automatic logic toggle_write(input hk_regs_pkg::reg_req_t req);
		return req.wr && req.addr == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES;
	endfunction

	// true for a read strobe aimed at one address
	function automatic logic read_at(input hk_regs_pkg::reg_req_t req, input logic [4:0] addr);
		return req.rd && req.addr == addr;
	endfunction

	// latches named by either toggle of their pair; the rest must hold
	function automatic logic [4:0] touched(input logic [9:0] wd);
		logic [4:0] hit;
		for (int i = 0; i < hk_regs_pkg::LATCH_W; i++)
			hit[i] = wd[2*i+1] | wd[2*i];
		return hit;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.busy_seen = i_conv_busy;
		// new result captured on the falling edge of busy
		if (state.busy_seen && !i_conv_busy
			&& i_conv_result.channel < 3'(hk_regs_pkg::NUM_CHANNELS))
			next_state.result[i_conv_result.channel] = i_conv_result.value;
		// toggle write only pulses latches, nothing kept
		if (toggle_write(i_req))
			next_state.latch = apply_toggles(state.latch, i_req.wdata);
		// read data only stands the cycle after the strobe
		next_state.rdata = hk_regs_pkg::READ_ZERO;
		if (i_req.rd)
		begin
			unique case (i_req.addr)
				hk_regs_pkg::ADDR_BACKUP_BATTERY_RESULT:  next_state.rdata = state.result[0];
				hk_regs_pkg::ADDR_AUX_INPUT_ONE_RESULT:   next_state.rdata = state.result[1];
				hk_regs_pkg::ADDR_AUX_INPUT_TWO_RESULT:   next_state.rdata = state.result[2];
				hk_regs_pkg::ADDR_AUX_INPUT_THREE_RESULT: next_state.rdata = state.result[3];
				hk_regs_pkg::ADDR_AUX_INPUT_FOUR_RESULT:  next_state.rdata = state.result[4];
				hk_regs_pkg::ADDR_CONV_STATUS:
					next_state.rdata = {9'h000, i_conv_busy};
				hk_regs_pkg::ADDR_POWER_LATCHES:
					next_state.rdata = {5'h00, state.latch};
				default:
					next_state.rdata = hk_regs_pkg::READ_ZERO;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers; clock enable freezes everything
	// ------------------------------------------------------------
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			state.result    <= {5{hk_regs_pkg::RESULT_RESET}};
			state.latch     <= hk_regs_pkg::LATCH_RESET;
			state.busy_seen <= 1'b0;
			state.rdata     <= hk_regs_pkg::READ_ZERO;
		end
		else if (i_enable)
			state <= next_state;
	end

	// outputs straight from flip-flops; low enable powers unit down
	assign o_rdata                  = state.rdata;
	assign o_conversion_in_progress = state.busy_seen;
	assign o_power_enables          = state.latch;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_clear_wins;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && i_req.wr && i_req.addr == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES
			&& i_req.wdata[9] && i_req.wdata[8]) |=> !o_power_enables[4];
	endproperty
	a_clear_wins: assert property (p_clear_wins) else $error("clear did not win");

	property p_set_conv;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && i_req.wr && i_req.addr == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES
			&& i_req.wdata[9] && !i_req.wdata[8]) |=> o_power_enables[4];
	endproperty
	a_set_conv: assert property (p_set_conv) else $error("converter latch not set");

	property p_set_up;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && i_req.wr && i_req.addr == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES
			&& i_req.wdata[1] && !i_req.wdata[0]) |=> o_power_enables[0];
	endproperty
	a_set_up: assert property (p_set_up) else $error("uplink latch not set");

	property p_zero_keeps;
		@(posedge i_clock) disable iff (!i_rst_n)
		!(i_req.wr && i_req.addr == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES)
			|=> $stable(o_power_enables);
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("latch changed without write");

	property p_clear_down;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && i_req.wr && i_req.addr == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES
			&& i_req.wdata[2]) |=> !o_power_enables[1];
	endproperty
	a_clear_down: assert property (p_clear_down) else $error("downlink latch not cleared");

	property p_read_backup;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && i_req.rd && i_req.addr == hk_regs_pkg::ADDR_BACKUP_BATTERY_RESULT)
			|=> o_rdata == $past(state.result[0]);
	endproperty
	a_read_backup: assert property (p_read_backup) else $error("backup read wrong");

	property p_read_status;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && i_req.rd && i_req.addr == hk_regs_pkg::ADDR_CONV_STATUS)
			|=> o_rdata == {9'h000, $past(i_conv_busy)};
	endproperty
	a_read_status: assert property (p_read_status) else $error("status read wrong");

	property p_capture;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && state.busy_seen && !i_conv_busy && i_conv_result.channel == 3'h1)
			|=> state.result[1] == $past(i_conv_result.value);
	endproperty
	a_capture: assert property (p_capture) else $error("result not captured");

	property p_unmapped;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && i_req.rd && i_req.addr == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES)
			|=> o_rdata == 10'h000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("toggle reg read not zero");

	property p_clear_conv;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && toggle_write(i_req) && i_req.wdata[8]) |=> !o_power_enables[4];
	endproperty
	a_clear_conv: assert property (p_clear_conv) else $error("converter latch not cleared");

	property p_set_freq;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && toggle_write(i_req) && i_req.wdata[7:6] == 2'b10) |=> o_power_enables[3];
	endproperty
	a_set_freq: assert property (p_set_freq) else $error("correction latch not set");

	property p_clear_freq;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && toggle_write(i_req) && i_req.wdata[6]) |=> !o_power_enables[3];
	endproperty
	a_clear_freq: assert property (p_clear_freq) else $error("correction latch not cleared");

	property p_set_aux_dac;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && toggle_write(i_req) && i_req.wdata[5:4] == 2'b10) |=> o_power_enables[2];
	endproperty
	a_set_aux_dac: assert property (p_set_aux_dac) else $error("aux dac latch not set");

	property p_clear_aux_dac;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && toggle_write(i_req) && i_req.wdata[4]) |=> !o_power_enables[2];
	endproperty
	a_clear_aux_dac: assert property (p_clear_aux_dac) else $error("aux dac latch not cleared");

	property p_set_down;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && toggle_write(i_req) && i_req.wdata[3:2] == 2'b10) |=> o_power_enables[1];
	endproperty
	a_set_down: assert property (p_set_down) else $error("downlink latch not set");

	property p_clear_up;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && toggle_write(i_req) && i_req.wdata[0]) |=> !o_power_enables[0];
	endproperty
	a_clear_up: assert property (p_clear_up) else $error("uplink latch not cleared");

	property p_untouched_keep;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && toggle_write(i_req)) |=>
			((o_power_enables ^ $past(o_power_enables)) & ~touched($past(i_req.wdata))) == '0;
	endproperty
	a_untouched_keep: assert property (p_untouched_keep) else $error("zero toggle moved a latch");

	property p_read_one;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && read_at(i_req, hk_regs_pkg::ADDR_AUX_INPUT_ONE_RESULT))
			|=> o_rdata == $past(state.result[1]);
	endproperty
	a_read_one: assert property (p_read_one) else $error("aux one read wrong");

	property p_read_two;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && read_at(i_req, hk_regs_pkg::ADDR_AUX_INPUT_TWO_RESULT))
			|=> o_rdata == $past(state.result[2]);
	endproperty
	a_read_two: assert property (p_read_two) else $error("aux two read wrong");

	property p_read_three;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && read_at(i_req, hk_regs_pkg::ADDR_AUX_INPUT_THREE_RESULT))
			|=> o_rdata == $past(state.result[3]);
	endproperty
	a_read_three: assert property (p_read_three) else $error("aux three read wrong");

	property p_read_four;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && read_at(i_req, hk_regs_pkg::ADDR_AUX_INPUT_FOUR_RESULT))
			|=> o_rdata == $past(state.result[4]);
	endproperty
	a_read_four: assert property (p_read_four) else $error("aux four read wrong");

	property p_read_latches;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && read_at(i_req, hk_regs_pkg::ADDR_POWER_LATCHES))
			|=> o_rdata == {5'h00, $past(state.latch)};
	endproperty
	a_read_latches: assert property (p_read_latches) else $error("latch readback wrong");

	property p_status_follows;
		@(posedge i_clock) disable iff (!i_rst_n)
		i_enable |=> o_conversion_in_progress == $past(i_conv_busy);
	endproperty
	a_status_follows: assert property (p_status_follows) else $error("busy copy wrong");

	property p_result_holds;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && !(state.busy_seen && !i_conv_busy)) |=> $stable(state.result);
	endproperty
	a_result_holds: assert property (p_result_holds) else $error("result moved without capture");

	property p_freeze;
		@(posedge i_clock) disable iff (!i_rst_n)
		!i_enable |=> $stable(state);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled"); // enable low freezes

	property p_rdata_idle;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && !i_req.rd) |=> o_rdata == 10'h000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read"); // one cycle only

	property p_capture_backup;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && state.busy_seen && !i_conv_busy && i_conv_result.channel == 3'h0)
			|=> state.result[0] == $past(i_conv_result.value);
	endproperty
	a_capture_backup: assert property (p_capture_backup) else $error("backup not captured");

	property p_capture_four;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && state.busy_seen && !i_conv_busy && i_conv_result.channel == 3'h4)
			|=> state.result[4] == $past(i_conv_result.value);
	endproperty
	a_capture_four: assert property (p_capture_four) else $error("aux four not captured");

	property p_ignore_channel;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_enable && state.busy_seen && !i_conv_busy && i_conv_result.channel > 3'h4)
			|=> $stable(state.result);
	endproperty
	a_ignore_channel: assert property (p_ignore_channel) else $error("bad channel stored");

	property p_reset_values;
		@(posedge i_clock)
		!i_rst_n |=> (o_power_enables == 5'h00 && o_rdata == 10'h000 && state.result == '0);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

endmodule

`default_nettype wire

// ===== testbench.sv
// self-checking bench for the housekeeping result and power toggle registers
// assumes hk_regs_pkg is compiled first and the register port never stalls
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic                      i_clock = 1'b0;
	logic                      i_rst_n = 1'b0;
	logic                      i_enable = 1'b1;
	hk_regs_pkg::reg_req_t     i_req = '0;
	logic                      i_conv_busy = 1'b0;
	hk_regs_pkg::conv_result_t i_conv_result = '0;
	logic [9:0]                o_rdata;
	logic                      o_conversion_in_progress;
	logic [4:0]                o_power_enables;
	int                        fail_count = 0;
	int                        n_tests = 0;
	logic [31:0]               seed = 32'hF5EC1206;
	logic [4:0]                m_latch = 5'h00;
	logic [9:0]                m_res [5];
	logic [9:0]                v;

	hk_regs hk_regs_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_enable(i_enable), .i_req(i_req),
		.i_conv_busy(i_conv_busy), .i_conv_result(i_conv_result), .o_rdata(o_rdata),
		.o_conversion_in_progress(o_conversion_in_progress), .o_power_enables(o_power_enables));

	// ----------------------------------------
	// clock, random source, shared tasks
	// ----------------------------------------
	always #2.5 i_clock = ~i_clock;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one-cycle strobes; checks land 1 ns after the answering edge
	task automatic wr(input logic [4:0] a, input logic [9:0] d);
		@(posedge i_clock);
		i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		i_req.wr <= 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			// clear wins when both toggles of a pair are written
			if (a == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES && d[2*i]) m_latch[i] = 1'b0;
			else if (a == hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES && d[2*i+1]) m_latch[i] = 1'b1;
		end
		#1 chk({5'h00, o_power_enables}, {5'h00, m_latch});
	endtask

	task automatic rd(input logic [4:0] a, input logic [9:0] exp);
		@(posedge i_clock);
		i_req <= '{addr: a, wdata: 10'h000, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock);
		i_req.rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask

	// busy high for a cycle, then low with the result presented
	task automatic conv(input int ch, input logic [9:0] val);
		@(posedge i_clock);
		i_conv_busy <= 1'b1;
		@(posedge i_clock);
		i_conv_busy <= 1'b0;
		i_conv_result <= '{channel: ch[2:0], value: val};
		#1 chk({9'h000, o_conversion_in_progress}, 10'h001);
		@(posedge i_clock);
		if (ch < 5) m_res[ch] = val;
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// watchdog and main sequence
	// ----------------------------------------
	initial
	begin
		#(20000 * 5);
		fail_count++;
		final_report();
	end

	initial
	begin
		foreach (m_res[i]) m_res[i] = 10'h000;
		repeat (8) @(posedge i_clock);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd(5'(hk_regs_pkg::ADDR_BACKUP_BATTERY_RESULT + i), 10'h000);
		rd(hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, 10'h000);
		// both voice paths powered together first, for their shared filter
		wr(hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, 10'h00A);
		rd(hk_regs_pkg::ADDR_POWER_LATCHES, 10'h003);
		// each latch set then cleared in turn, then every set at once
		for (int i = 0; i < 10; i++) wr(hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, 10'h001 << (i ^ 1));
		wr(hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, 10'h2AA);
		// enable low freezes the block: this clear-all write is refused
		@(posedge i_clock);
		i_enable <= 1'b0;
		i_req <= '{addr: hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, wdata: 10'h3FF, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		i_enable <= 1'b1;
		i_req.wr <= 1'b0;
		#1 chk({5'h00, o_power_enables}, {5'h00, m_latch});
		wr(hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, 10'h000);
		wr(hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, 10'h3FF);
		for (int i = 0; i < 30; i++)
		begin
			v = 10'(xs());
			wr((i % 7 == 0) ? 5'h05 : hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, v);
		end
		rd(hk_regs_pkg::ADDR_POWER_LATCHES, {5'h00, m_latch});
		// a capture per channel, an ignored channel, then read back
		for (int r = 0; r < 3; r++)
			for (int c = 0; c < 6; c++)
			begin
				v = 10'(xs());
				conv((c == 5) ? 7 : c, v);
			end
		// results trusted only with the converter idle and powered
		wr(hk_regs_pkg::ADDR_POWER_TOGGLE_PULSES, 10'h200);
		i_conv_busy <= 1'b1;
		rd(hk_regs_pkg::ADDR_CONV_STATUS, 10'h001);
		i_conv_busy <= 1'b0;
		rd(hk_regs_pkg::ADDR_CONV_STATUS, 10'h000);
		for (int i = 0; i < 5; i++)
			rd(5'(hk_regs_pkg::ADDR_BACKUP_BATTERY_RESULT + i), m_res[i]);
		rd(5'h1F, 10'h000);
		// mid-run reset clears every result and latch
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		m_latch = 5'h00;
		foreach (m_res[i]) m_res[i] = 10'h000;
		for (int i = 0; i < 5; i++)
			rd(5'(hk_regs_pkg::ADDR_BACKUP_BATTERY_RESULT + i), m_res[i]);
		rd(hk_regs_pkg::ADDR_POWER_LATCHES, {5'h00, m_latch});
		final_report();
	end
endmodule

`default_nettype wire
